// >>> tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic        clk_sys, rst_n, hsel, hwrite, bus_out_par, svc_out, cmd_out, at_bot, file_prot, tmg, bb;
    logic        hreadyout, hresp, svc_in, move_tag, burst_tag, erase_tag, ctl_tag, tm_tag, nrzi_sel;
    logic        wr_stb, wr_par, gap_ctl, tach_pulse, rb_stb, rb_par, tm_ok, unit_ok;
    logic        dual_den, skew_err, at_eot, write_stat;
    logic [1:0]  htrans;
    logic [7:0]  bus_out, wr_data, rb_data, wq[$], sd[$];
    logic [31:0] haddr, hwdata, hrdata, r, rs, e;
    int          n_mismatch, n_compared, ntm, ner;
    twbs_top #(.DATA_PER_CYC(24'h8), .TACH_TMO_CYC(24'h32), .TACH_MIN_CYC(24'h4), .TACH_MAX_CYC(24'h8),
        .BURST_CYC(24'h32), .LPD_CYC(24'h32), .ERG_CYC(24'h32), .TM_WAIT_CYC(24'h32)) i_twbs_top (.hsize(3'h2),
        .hready(hreadyout), .*);
    twbs_unit i_twbs_unit (.tm_good(tmg), .*);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(negedge clk_sys) begin
        bb |= burst_tag && wq.size() == 0;
        ntm += tm_tag;
        ner += erase_tag;
        if (wr_stb) wq.push_back(wr_data);
    end
    function automatic [31:0] lf(input [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input logic [31:0] s, x);
        n_compared++;
        if (s !== x) begin
            n_mismatch++;
            $display("mismatch %0t seen %h expected %h", $time, s, x);
        end
    endtask
    task automatic close_out;
        if (n_mismatch == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic ws(input logic v);
        do @(negedge clk_sys); while (svc_in !== v);
        @(posedge clk_sys);
    endtask
    task automatic host(input int n, bi);
        for (int k = 0; k < n; k++) begin
            ws(1'b1);
            rs = lf(rs);
            sd.push_back(rs[7:0]);
            bus_out <= rs[7:0];
            bus_out_par <= ~^rs[7:0] ^ (k == bi);
            svc_out <= 1'b1;
            ws(1'b0);
            svc_out <= 1'b0;
        end
        ws(1'b1);
        cmd_out <= 1'b1;
        ws(1'b0);
        cmd_out <= 1'b0;
    endtask
    task automatic idle;
        do ahb(1'b0, 32'h4, 32'h0); while (r[10] === 1'b1);
    endtask
    initial begin
        {rst_n, hsel, hwrite, bus_out_par, svc_out, cmd_out, at_bot, file_prot, tmg, bb} = 10'h0;
        {htrans, haddr, hwdata, bus_out} = 74'h0;
        {dual_den, skew_err, at_eot, write_stat} = 4'h1;
        rs = 32'h1c40;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        ahb(1'b0, 32'hc, 32'h0);
        chk(r, 32'h0);
        at_bot <= 1'b1;
        ahb(1'b1, 32'h0, 32'h101);
        host(64, 5);
        idle;
        chk(bb, 32'h1);
        chk(wq.size(), 32'h92);
        foreach (wq[k]) begin
            e = (k < 40 || k > 105) ? 32'h0 : (k == 40 || k == 105) ? 32'hff : sd[k-41];
            chk(wq[k], e);
        end
        ahb(1'b0, 32'h4, 32'h0);
        chk(r[9:0], 10'h1);
        at_bot <= 1'b0;
        skew_err <= 1'b1;
        wq = {};
        sd = {};
        ahb(1'b1, 32'h0, 32'h111);
        host(128, -1);
        idle;
        e = 32'h0;
        foreach (sd[k]) e ^= sd[k];
        chk(wq.size(), 32'h82);
        chk(wq[129], e);
        ahb(1'b0, 32'h4, 32'h0);
        chk(r & 32'h43ff, 32'h4202);
        skew_err <= 1'b0;
        ahb(1'b1, 32'h0, 32'h103);
        idle;
        chk(ntm, 32'hf);
        chk(r[9:0], 10'h40);
        tmg <= 1'b1;
        ahb(1'b1, 32'h0, 32'h103);
        idle;
        chk(r[9:0], 10'h0);
        ahb(1'b1, 32'h0, 32'h102);
        idle;
        chk(ner, 32'h32);
        file_prot <= 1'b1;
        ahb(1'b1, 32'h0, 32'h104);
        idle;
        chk(r[9:0], 10'h80);
        close_out;
    end
    initial begin
        #1000000;
        n_mismatch++;
        close_out;
    end
endmodule // tb_top

// >>> twbs_chk.sv
`timescale 1ns/1ns
module twbs_chk (
    input wire       clk_sys, rst_n, hreadyout, hresp, svc_out, svc_in,
    input wire       wr_stb, wr_par, move_tag, erase_tag, tm_tag,
    input wire [7:0] wr_data
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_rdy; hreadyout && !hresp; endproperty
    a_rdy: assert property (p_rdy) else $error("bus stall");
    property p_take; svc_in && svc_out |-> ##[1:4] !svc_in; endproperty
    a_take: assert property (p_take) else $error("byte not taken");
    property p_next; $rose(svc_in) |-> !$past(svc_out, 2); endproperty
    a_next: assert property (p_next) else $error("early request");
    property p_par; wr_stb |-> ^{wr_data, wr_par}; endproperty
    a_par: assert property (p_par) else $error("even parity");
    property p_slot; wr_stb |=> !wr_stb [*7]; endproperty
    a_slot: assert property (p_slot) else $error("short slot");
    property p_tm; tm_tag |=> !tm_tag; endproperty
    a_tm: assert property (p_tm) else $error("long mark");
    property p_mov; wr_stb |-> move_tag; endproperty
    a_mov: assert property (p_mov) else $error("no motion");
    property p_erg; erase_tag |-> move_tag && !wr_stb; endproperty
    a_erg: assert property (p_erg) else $error("erase clash");
    c_wr: cover property (wr_stb);
    c_tm: cover property (tm_tag);
    c_erg: cover property (erase_tag);
endmodule // twbs_chk
bind twbs_top twbs_chk i_twbs_chk (.*);

// >>> twbs_regs.vh
`ifndef TWBS_REGS_VH
`define TWBS_REGS_VH

// ----------------------------------------------------------------
// register byte offsets and the control register reset value
// ----------------------------------------------------------------
`define TWBS_OFS_CTRL      8'h00
`define TWBS_OFS_STAT      8'h04
`define TWBS_OFS_WCNT      8'h08
`define TWBS_CTRL_RST      8'h00

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define TWBS_CTRL_CMD_HI   2
`define TWBS_CTRL_CMD_LO   0
`define TWBS_CTRL_NRZI     4
`define TWBS_CTRL_MSET     5
`define TWBS_CTRL_GO       8
`define TWBS_CMD_WRITE     3'h1
`define TWBS_CMD_ERG       3'h2
`define TWBS_CMD_WTM       3'h3
`define TWBS_CMD_DSE       3'h4

// ----------------------------------------------------------------
// status bits
// ----------------------------------------------------------------
`define TWBS_E_BUSOUT      0
`define TWBS_E_OVERRUN     1
`define TWBS_E_VPAR        2
`define TWBS_E_TAPEVEL     3
`define TWBS_E_TACH        4
`define TWBS_E_STARTVEL    5
`define TWBS_E_TMCHK       6
`define TWBS_E_UREJ        7
`define TWBS_E_CCHK        8
`define TWBS_E_SKEW        9

// ----------------------------------------------------------------
// framing counts
// ----------------------------------------------------------------
`define TWBS_PRE_LEN       8'h28
`define TWBS_MARK          8'hff
`define TWBS_VEL_MIN       8'h70
`define TWBS_VEL_MAX       8'h80
`define TWBS_CC_SPACE      2'h3
`define TWBS_END_PERIODS   5'h10
`define TWBS_TM_TRIES      4'hf
`define TWBS_ERG_INCH      3

// ----------------------------------------------------------------
// timing, in ns, and the clock period
// ----------------------------------------------------------------
`define TWBS_CLK_NS        10
`define TWBS_DATA_PER_NS   1000
`define TWBS_TACH_TMO_NS   5000000
`define TWBS_TACH_MIN_NS   20000
`define TWBS_TACH_MAX_NS   40000
`define TWBS_ID_BURST_NS   2000000
`define TWBS_LPD_NS        2000000
`define TWBS_INCH_NS       5000000
`define TWBS_TM_WAIT_NS    100000
`define TWBS_UNIT_WAIT_NS  1000

`endif

// >>> twbs_top.v
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ns
`include "twbs_regs.vh"
module twbs_top #(
    parameter [23:0] DATA_PER_CYC = `TWBS_DATA_PER_NS / `TWBS_CLK_NS,
    parameter [23:0] TACH_TMO_CYC = `TWBS_TACH_TMO_NS / `TWBS_CLK_NS,
    parameter [23:0] TACH_MIN_CYC = (`TWBS_TACH_MIN_NS + `TWBS_CLK_NS - 1) / `TWBS_CLK_NS,
    parameter [23:0] TACH_MAX_CYC = `TWBS_TACH_MAX_NS / `TWBS_CLK_NS,
    parameter [23:0] BURST_CYC    = `TWBS_ID_BURST_NS / `TWBS_CLK_NS,
    parameter [23:0] LPD_CYC      = `TWBS_LPD_NS / `TWBS_CLK_NS,
    parameter [23:0] ERG_CYC      = `TWBS_ERG_INCH * `TWBS_INCH_NS / `TWBS_CLK_NS,
    parameter [23:0] TM_WAIT_CYC  = `TWBS_TM_WAIT_NS / `TWBS_CLK_NS,
    parameter [23:0] UNIT_WAIT_CYC = `TWBS_UNIT_WAIT_NS / `TWBS_CLK_NS,
    parameter [7:0]  CRC_POLY     = 8'h07
) (
    // system
    input  wire        clk_sys,
    input  wire        rst_n,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // host channel
    input  wire [7:0]  bus_out,
    input  wire        bus_out_par,
    input  wire        svc_out,
    input  wire        cmd_out,
    output reg         svc_in,
    // tape unit outputs
    output reg         move_tag,
    output reg         burst_tag,
    output reg         erase_tag,
    output reg         ctl_tag,
    output reg         tm_tag,
    output reg         nrzi_sel,
    output reg         wr_stb,
    output reg  [7:0]  wr_data,
    output reg         wr_par,
    // tape unit inputs
    input  wire        gap_ctl,
    input  wire        tach_pulse,
    input  wire        rb_stb,
    input  wire [7:0]  rb_data,
    input  wire        rb_par,
    input  wire        tm_ok,
    input  wire        unit_ok,
    input  wire        skew_err,
    input  wire        at_bot,
    input  wire        at_eot,
    input  wire        file_prot,
    input  wire        write_stat,
    input  wire        dual_den
);

// ----------------------------------------------------------------
// states
// ----------------------------------------------------------------
localparam [4:0] ST_IDLE  = 5'h00;
localparam [4:0] ST_SETUP = 5'h01;
localparam [4:0] ST_MOVE  = 5'h02;
localparam [4:0] ST_TACH1 = 5'h03;
localparam [4:0] ST_TACH2 = 5'h04;
localparam [4:0] ST_BURST = 5'h05;
localparam [4:0] ST_LPD   = 5'h06;
localparam [4:0] ST_PRE   = 5'h07;
localparam [4:0] ST_REQ   = 5'h08;
localparam [4:0] ST_WB    = 5'h09;
localparam [4:0] ST_SOCHK = 5'h0a;
localparam [4:0] ST_POST  = 5'h0b;
localparam [4:0] ST_CC    = 5'h0c;
localparam [4:0] ST_ENDW  = 5'h0d;
localparam [4:0] ST_ERG   = 5'h0e;
localparam [4:0] ST_TM    = 5'h0f;
localparam [4:0] ST_TMW   = 5'h10;
localparam [4:0] ST_DSE   = 5'h11;
localparam [4:0] ST_DSEW  = 5'h12;
localparam [4:0] ST_STOP  = 5'h13;
localparam       NS       = 31;

// ----------------------------------------------------------------
// input synchronisers
// ----------------------------------------------------------------
wire [NS-1:0] raw_in = {dual_den, write_stat, file_prot, at_eot, at_bot, skew_err, unit_ok, tm_ok,
                        rb_par, rb_data, rb_stb, tach_pulse, gap_ctl, cmd_out, svc_out,
                        bus_out_par, bus_out};
reg  [NS-1:0] s1_ff;
reg  [NS-1:0] s2_ff;
reg           rbs_d_ff;
reg           tach_d_ff;

always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        s1_ff     <= {NS{1'b0}};
        s2_ff     <= {NS{1'b0}};
        rbs_d_ff  <= 1'b0;
        tach_d_ff <= 1'b0;
    end else begin
        s1_ff     <= raw_in;
        s2_ff     <= s1_ff;
        rbs_d_ff  <= s2_ff[13];
        tach_d_ff <= s2_ff[12];
    end
end

wire [7:0] bo_d   = s2_ff[7:0];
wire       bo_ok  = ^s2_ff[8:0];
wire       so     = s2_ff[9];
wire       co     = s2_ff[10];
wire       gap    = s2_ff[11];
wire       tach_e = s2_ff[12] & ~tach_d_ff;
wire       rb_e   = s2_ff[13] & ~rbs_d_ff;
wire [7:0] rb_d   = s2_ff[21:14];
wire       rb_ok  = ^s2_ff[22:14];
wire       tmok   = s2_ff[23];
wire       uok    = s2_ff[24];
wire       skew   = s2_ff[25];
wire       beginning_of_tape_marker    = s2_ff[26];
wire       end_of_tape_marker    = s2_ff[27];
wire       fprot  = s2_ff[28];
wire       wst    = s2_ff[29];
wire       dden   = s2_ff[30];

// ----------------------------------------------------------------
// block state
// ----------------------------------------------------------------
reg [4:0]  st_ff;
reg [7:0]  ctrl_ff;
reg [9:0]  err_ff;
reg        busy_ff;
reg        end_ind_ff;
reg        lrc_st_ff;
reg        end_data_ff;
reg        bot_ff;
reg [23:0] tmr_ff;
reg [23:0] slot_ff;
reg [7:0]  bcnt_ff;
reg [15:0] wcnt_ff;
reg [15:0] rcnt_ff;
reg [7:0]  vcnt_ff;
reg        rb_seen_ff;
reg        no_noise_ff;
reg [1:0]  sp_ff;
reg [4:0]  ecnt_ff;
reg [3:0]  tries_ff;
reg [7:0]  data_ff;
reg [7:0]  lrc_ff;
reg [7:0]  crc_ff;
reg [7:0]  aaddr_ff;
reg        awr_ff;
reg        aval_ff;

wire [2:0] cmd    = ctrl_ff[`TWBS_CTRL_CMD_HI:`TWBS_CTRL_CMD_LO];
wire       slot   = (slot_ff == 24'h000000);
wire       wr_reg = aval_ff & awr_ff;
wire       go     = wr_reg & (aaddr_ff == `TWBS_OFS_CTRL) & hwdata[`TWBS_CTRL_GO] & ~busy_ff;
wire [7:0] crc_nx = {crc_ff[6:0], 1'b0} ^ (crc_ff[7] ? CRC_POLY : 8'h00) ^ data_ff;
wire [4:0] st_body = (cmd == `TWBS_CMD_ERG) ? ST_ERG :
                     (cmd == `TWBS_CMD_WTM) ? ST_TM  :
                     nrzi_sel ? ST_REQ : ST_PRE;
// dual-density units at load point need a prior mode set
wire       nrzi_m = ctrl_ff[`TWBS_CTRL_NRZI] & (~beginning_of_tape_marker | ~dden | ctrl_ff[`TWBS_CTRL_MSET]);
wire [31:0] stat_w = {17'h00000, nrzi_sel, end_data_ff, lrc_st_ff, end_ind_ff, busy_ff, err_ff};

// ----------------------------------------------------------------
// ahb-lite slave, zero wait states
// ----------------------------------------------------------------
reg [31:0] rd_mux;
always @* begin
    case (haddr[7:0])
        `TWBS_OFS_CTRL: rd_mux = {24'h000000, ctrl_ff};
        `TWBS_OFS_STAT: rd_mux = stat_w;
        `TWBS_OFS_WCNT: rd_mux = {16'h0000, wcnt_ff};
        default:        rd_mux = 32'h00000000;
    endcase
end

always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        hrdata    <= 32'h00000000;
        hreadyout <= 1'b1;
        hresp     <= 1'b0;
        aaddr_ff  <= 8'h00;
        awr_ff    <= 1'b0;
        aval_ff   <= 1'b0;
        ctrl_ff   <= `TWBS_CTRL_RST;
    end else begin
        hreadyout <= 1'b1;
        hresp     <= 1'b0;
        aval_ff   <= hsel & htrans[1] & hready;
        if (hsel & htrans[1] & hready) begin
            aaddr_ff <= haddr[7:0];
            awr_ff   <= hwrite;
            hrdata   <= rd_mux;
        end
        // command fields are frozen while an operation runs
        if (wr_reg & (aaddr_ff == `TWBS_OFS_CTRL) & ~busy_ff)
            ctrl_ff <= {2'b00, hwdata[5:4], 1'b0, hwdata[2:0]};
    end
end

// ----------------------------------------------------------------
// sequencer
// ----------------------------------------------------------------
always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
        st_ff <= ST_IDLE;
        err_ff <= 10'h000;
        busy_ff <= 1'b0;
        end_ind_ff <= 1'b0;
        lrc_st_ff <= 1'b0;
        end_data_ff <= 1'b0;
        bot_ff <= 1'b0;
        tmr_ff <= 24'h000000;
        slot_ff <= 24'h000000;
        bcnt_ff <= 8'h00;
        wcnt_ff <= 16'h0000;
        rcnt_ff <= 16'h0000;
        vcnt_ff <= 8'h00;
        rb_seen_ff <= 1'b0;
        no_noise_ff <= 1'b0;
        sp_ff <= 2'h0;
        ecnt_ff <= 5'h00;
        tries_ff <= 4'h0;
        data_ff <= 8'h00;
        lrc_ff <= 8'h00;
        crc_ff <= 8'h00;
        svc_in <= 1'b0;
        move_tag <= 1'b0;
        burst_tag <= 1'b0;
        erase_tag <= 1'b0;
        ctl_tag <= 1'b0;
        tm_tag <= 1'b0;
        nrzi_sel <= 1'b0;
        wr_stb <= 1'b0;
        wr_data <= 8'h00;
        wr_par <= 1'b0;
    end else begin
        wr_stb <= 1'b0;
        tm_tag <= 1'b0;
        slot_ff <= slot ? DATA_PER_CYC - 24'h000001 : slot_ff - 24'h000001;
        if (tmr_ff != 24'h000000)
            tmr_ff <= tmr_ff - 24'h000001;
        case (st_ff)
            ST_IDLE: begin
                if (go) begin
                    err_ff <= 10'h000;
                    busy_ff <= 1'b1;
                    end_ind_ff <= 1'b0;
                    lrc_st_ff <= 1'b0;
                    end_data_ff <= 1'b0;
                    {bcnt_ff, vcnt_ff, tries_ff} <= 20'h00000;
                    {wcnt_ff, rcnt_ff} <= 32'h00000000;
                    {rb_seen_ff, no_noise_ff} <= 2'b00;
                    {lrc_ff, crc_ff} <= 16'h0000;
                    st_ff <= ST_SETUP;
                end
            end
            ST_SETUP: begin
                bot_ff <= beginning_of_tape_marker;
                nrzi_sel <= nrzi_m;
                if (cmd == `TWBS_CMD_DSE) begin
                    st_ff <= ST_DSE;
                end else begin
                    move_tag <= 1'b1;
                    tmr_ff <= TACH_TMO_CYC;
                    st_ff <= ST_MOVE;
                end
            end
            ST_MOVE: begin
                if (gap) begin
                    tmr_ff <= TACH_TMO_CYC;
                    st_ff <= ST_TACH1;
                end else if (tmr_ff == 24'h000000) begin
                    err_ff[`TWBS_E_TACH] <= 1'b1;
                    st_ff <= ST_STOP;
                end
            end
            ST_TACH1: begin
                if (tach_e) begin
                    tmr_ff <= TACH_MAX_CYC + TACH_MAX_CYC;
                    st_ff <= ST_TACH2;
                end else if (tmr_ff == 24'h000000) begin
                    err_ff[`TWBS_E_TACH] <= 1'b1;
                    st_ff <= ST_STOP;
                end
            end
            ST_TACH2: begin
                // tmr counts down from twice the longest pulse spacing
                if (tmr_ff == 24'h000000) begin
                    err_ff[`TWBS_E_TACH] <= 1'b1;
                    st_ff <= ST_STOP;
                end else if (tach_e) begin
                    if ((tmr_ff > TACH_MAX_CYC + TACH_MAX_CYC - TACH_MIN_CYC) | (tmr_ff < TACH_MAX_CYC))
                        err_ff[`TWBS_E_STARTVEL] <= 1'b1;
                    if (bot_ff & ~nrzi_sel) begin
                        burst_tag <= 1'b1;
                        tmr_ff <= BURST_CYC;
                        st_ff <= ST_BURST;
                    end else if (bot_ff) begin
                        tmr_ff <= LPD_CYC;
                        st_ff <= ST_LPD;
                    end else begin
                        st_ff <= st_body;
                    end
                end
            end
            ST_BURST, ST_LPD: begin
                if (tmr_ff == 24'h000000) begin
                    burst_tag <= 1'b0;
                    st_ff <= st_body;
                end
            end
            ST_PRE: begin
                if (slot) begin
                    wr_stb <= 1'b1;
                    wr_data <= (bcnt_ff == `TWBS_PRE_LEN) ? `TWBS_MARK : 8'h00;
                    // zero and all-ones bytes both need the parity bit set for odd parity
                    wr_par <= 1'b1;
                    bcnt_ff <= bcnt_ff + 8'h01;
                    if (bcnt_ff == `TWBS_PRE_LEN)
                        st_ff <= ST_REQ;
                end
            end
            ST_REQ: begin
                if (so) begin
                    data_ff <= bo_d;
                    if (!bo_ok)
                        err_ff[`TWBS_E_BUSOUT] <= 1'b1;
                    svc_in <= 1'b0;
                    st_ff <= ST_WB;
                end else if (co) begin
                    svc_in <= 1'b0;
                    if (nrzi_sel)
                        err_ff[`TWBS_E_OVERRUN] <= 1'b1;
                    end_ind_ff <= 1'b1;
                    bcnt_ff <= 8'h00;
                    sp_ff <= 2'h0;
                    st_ff <= nrzi_sel ? ST_CC : ST_POST;
                end else begin
                    svc_in <= 1'b1;
                end
            end
            ST_WB: begin
                if (slot) begin
                    if (nrzi_sel) begin
                        lrc_ff <= lrc_ff ^ data_ff;
                        crc_ff <= crc_nx;
                    end
                    wr_stb <= 1'b1;
                    wr_data <= data_ff;
                    wr_par <= ~^data_ff;
                    wcnt_ff <= wcnt_ff + 16'h0001;
                    st_ff <= ST_SOCHK;
                end
            end
            ST_SOCHK: begin
                // wait one slot so the synced service out has time to fall
                if (slot) begin
                    // service out still high, or command out in NRZI mode: the channel outran us
                    if (so | (nrzi_sel & co)) begin
                        err_ff[`TWBS_E_OVERRUN] <= 1'b1;
                        end_ind_ff <= 1'b1;
                        bcnt_ff <= 8'h00;
                        sp_ff <= 2'h0;
                        st_ff <= nrzi_sel ? ST_CC : ST_POST;
                    end else begin
                        svc_in <= 1'b1;
                        st_ff <= ST_REQ;
                    end
                end
            end
            ST_POST: begin
                if (slot) begin
                    wr_stb <= 1'b1;
                    wr_data <= (bcnt_ff == 8'h00) ? `TWBS_MARK : 8'h00;
                    wr_par <= 1'b1;
                    bcnt_ff <= bcnt_ff + 8'h01;
                    if (bcnt_ff == `TWBS_PRE_LEN) begin
                        ecnt_ff <= 5'h00;
                        st_ff <= ST_ENDW;
                    end
                end
            end
            ST_CC: begin
                if (slot) begin
                    sp_ff <= sp_ff + 2'h1;
                    if (sp_ff == `TWBS_CC_SPACE - 2'h1) begin
                        sp_ff <= 2'h0;
                        wr_stb <= 1'b1;
                        wr_data <= lrc_st_ff ? lrc_ff : crc_ff;
                        wr_par <= lrc_st_ff ? ~^lrc_ff : ~^crc_ff;
                        lrc_st_ff <= 1'b1;
                        if (lrc_st_ff) begin
                            end_data_ff <= 1'b1;
                            ecnt_ff <= 5'h00;
                            st_ff <= ST_ENDW;
                        end
                    end
                end
            end
            ST_ENDW: begin
                if (slot)
                    ecnt_ff <= ecnt_ff + 5'h01;
                if (ecnt_ff == `TWBS_END_PERIODS) begin
                    if (skew)
                        err_ff[`TWBS_E_SKEW] <= 1'b1;
                    st_ff <= ST_STOP;
                end
            end
            ST_ERG: begin
                if (!erase_tag) begin
                    erase_tag <= 1'b1;
                    tmr_ff <= ERG_CYC - 24'h000001;
                end else if (tmr_ff == 24'h000000) begin
                    erase_tag <= 1'b0;
                    st_ff <= ST_STOP;
                end
            end
            ST_TM: begin
                tm_tag <= 1'b1;
                tmr_ff <= TM_WAIT_CYC;
                st_ff <= ST_TMW;
            end
            ST_TMW: begin
                if (tmok) begin
                    st_ff <= ST_STOP;
                end else if (tmr_ff == 24'h000000) begin
                    tries_ff <= tries_ff + 4'h1;
                    if (tries_ff == `TWBS_TM_TRIES - 4'h1) begin
                        err_ff[`TWBS_E_TMCHK] <= 1'b1;
                        st_ff <= ST_STOP;
                    end else begin
                        st_ff <= ST_TM;
                    end
                end
            end
            ST_DSE: begin
                if (wst & ~end_of_tape_marker & ~fprot) begin
                    ctl_tag <= 1'b1;
                    tmr_ff <= UNIT_WAIT_CYC;
                    st_ff <= ST_DSEW;
                end else begin
                    err_ff[`TWBS_E_UREJ] <= 1'b1;
                    st_ff <= ST_STOP;
                end
            end
            ST_DSEW: begin
                if (tmr_ff == 24'h000000) begin
                    ctl_tag <= 1'b0;
                    if (!uok)
                        err_ff[`TWBS_E_UREJ] <= 1'b1;
                    st_ff <= ST_STOP;
                end
            end
            ST_STOP: begin
                {svc_in, move_tag, burst_tag, erase_tag, ctl_tag} <= 5'h00;
                busy_ff <= 1'b0;
                st_ff <= ST_IDLE;
            end
            default: begin
                st_ff <= ST_STOP;
            end
        endcase

        // velocity window on the first read-back byte
        if (wr_stb & ~rb_seen_ff & (vcnt_ff != `TWBS_VEL_MAX))
            vcnt_ff <= vcnt_ff + 8'h01;
        if (busy_ff & ~rb_seen_ff & (vcnt_ff == `TWBS_VEL_MAX))
            err_ff[`TWBS_E_TAPEVEL] <= 1'b1;
        if (busy_ff & rb_e) begin
            rcnt_ff <= rcnt_ff + 16'h0001;
            ecnt_ff <= 5'h00;
            if (!rb_seen_ff) begin
                rb_seen_ff <= 1'b1;
                no_noise_ff <= (vcnt_ff >= `TWBS_VEL_MIN);
            end
            if (!rb_ok | (rb_seen_ff ? ~no_noise_ff : (vcnt_ff < `TWBS_VEL_MIN)))
                err_ff[`TWBS_E_VPAR] <= 1'b1;
            if (nrzi_sel & (rcnt_ff == wcnt_ff) & (rb_d != crc_ff))
                err_ff[`TWBS_E_CCHK] <= 1'b1;
            if (nrzi_sel & (rcnt_ff == wcnt_ff + 16'h0001) & (rb_d != lrc_ff))
                err_ff[`TWBS_E_CCHK] <= 1'b1;
        end
    end
end

endmodule // twbs_top

// >>> twbs_unit.sv
`timescale 1ns/1ns
module twbs_unit (
    input  wire       clk_sys, rst_n, tm_good, move_tag, tm_tag, ctl_tag, wr_stb, wr_par,
    input  wire [7:0] wr_data,
    output reg        gap_ctl, tach_pulse, rb_stb, rb_par, tm_ok, unit_ok,
    output reg  [7:0] rb_data
);
    logic [8:0] q[$];
    logic [2:0] tc;
    int         idl;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q = {};
            idl <= 0;
            {gap_ctl, tach_pulse, rb_stb, rb_par, tm_ok, unit_ok, rb_data, tc} <= 17'h0;
        end else begin
            // read head trails by ~120 bytes; tail drains after writes stop
            if (wr_stb) q.push_back({wr_par, wr_data});
            idl <= wr_stb ? 0 : idl + 1;
            rb_stb <= 1'b0;
            if (q.size() > 120 || (q.size() > 0 && !wr_stb && idl > 40 && idl % 8 == 0)) begin
                {rb_par, rb_data} <= q.pop_front();
                rb_stb <= 1'b1;
            end else
                {rb_par, rb_data} <= ~{rb_par, rb_data};
            gap_ctl <= move_tag;
            tc <= (move_tag && tc != 3'h5) ? tc + 3'h1 : 3'h0;
            tach_pulse <= tc == 3'h5;
            tm_ok <= tm_good & tm_tag;
            unit_ok <= ctl_tag;
        end
    end
endmodule // twbs_unit
